// file: rtl/ecp_port_defines.vh
// Purpose: shared constants for the printer port FIFO and configuration block
// Assumes: 32-bit Avalon-MM data, byte addressing, byte offsets below
// Notes: definitions only
`ifndef ECP_PORT_DEFINES_VH
`define ECP_PORT_DEFINES_VH

// register byte offsets
`define OFS_FIFO_PORT 8'h00
`define OFS_IRQ_INFO 8'h04
`define OFS_ECR 8'h08
`define OFS_DCR 8'h0C
`define OFS_PORT_STAT 8'h10

// mode field encodings
`define MODE_SPP 3'h0
`define MODE_PS2 3'h1
`define MODE_FIFO 3'h2
`define MODE_ECP 3'h3
`define MODE_TEST 3'h6
`define MODE_CFG 3'h7

// ecr field positions
`define ECR_MODE_HI 7
`define ECR_MODE_LO 5
`define ECR_ERR_DIS 4
`define ECR_DMA_EN 3
`define ECR_SVC 2
`define ECR_FULL 1
`define ECR_EMPTY 0

// reset values and constants
`define ECR_RESET 8'h15
`define IMPL_INFO_VALUE 8'h10
`define IRQ_LOW_BITS 3'h7
`define IRQ_SEL_RESET 3'h0

// fifo geometry
`define FIFO_DEPTH 16
`define FIFO_AW 4

// handshake timing
`define STROBE_NS 500
`define CLK_NS 40
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define ACK_TIMEOUT_CYC 255

`endif

// file: rtl/byte_fifo_mem.v
// Purpose: 16x8 storage for the shared port fifo
// Assumes: one write and one read port, same clock
// Notes: read data is registered
`timescale 1ns/1ps
`default_nettype none
`include "ecp_port_defines.vh"
module byte_fifo_mem (
    input wire core_clk,
    input wire wr_en,
    input wire [`FIFO_AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [`FIFO_AW-1:0] rd_addr,
    output reg [7:0] rd_data_ff
);
    reg [7:0] mem [0:`FIFO_DEPTH-1];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule // byte_fifo_mem
`default_nettype wire

// file: rtl/sync2.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input asynchronous to core_clk
// Notes: first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out_ff
);
    reg [WIDTH-1:0] meta_ff;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_out_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_out_ff <= meta_ff;
        end
    end
endmodule // sync2
`default_nettype wire

// file: rtl/ecp_port_fifo.v
// Purpose: printer port fifo paths, configuration and extended control registers
// Assumes: Avalon-MM slave, 32-bit data, byte offsets, one clock
// Notes: forward/reverse handshakes simplified to strobe/busy and ack/req pairs
// Functional notes
// - fifo mode only sends forward, host to peripheral
// - fifo mode sends every host byte with printer-port strobe handshake
// - host fifo transfers are whole bytes, no packing
// - ecp mode, direction 0: host bytes sent by ecp handshake
// - ecp mode, direction 1: peripheral bytes captured into fifo
// - reverse reads return received bytes in arrival order
// - test mode lets host write and read fifo in any direction
// - test mode performs no handshake to the peripheral
// - test mode may show fifo bytes on data pins, no strobe
// - implementation info reads constant 10h in configuration mode
// - compression bit reads zero
// - interrupt level bit reflects current assigned interrupt line
// - bits 5:3 report interrupt assignment code
// - three low bits accept writes but read as ones
// - extended control reachable in every mode with its fields
// - all fifo paths share one sixteen-byte fifo
// - extended control bits 7:5 select mode, read/write
// - standard printer-port mode holds fifo in reset
`timescale 1ns/1ps
`default_nettype none
`include "ecp_port_defines.vh"
module ecp_port_fifo (
    input wire core_clk,
    input wire sys_rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire irq_line_in,
    input wire [2:0] irq_assign,
    input wire dma_ack,
    output reg dma_req_ff,
    input wire [7:0] pd_in,
    output reg [7:0] pd_out_ff,
    output reg pd_oe_n_ff,
    output reg strobe_n_ff,
    output reg host_ack_n_ff,
    input wire busy_in,
    input wire peri_ack_n_in,
    output reg error_interrupt_disable_ff
);
    // pin synchronisers
    wire [7:0] pd_sync;
    wire busy_sync;
    wire peri_ack_n_sync;
    wire irq_sync;

    sync2 #(.WIDTH(8)) u_pd_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(pd_in),
        .sync_out_ff(pd_sync)
    );
    sync2 #(.WIDTH(3)) u_ctl_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({busy_in, peri_ack_n_in, irq_line_in}),
        .sync_out_ff({busy_sync, peri_ack_n_sync, irq_sync})
    );

    // control registers
    reg [2:0] mode_ff;
    reg dma_transfer_enable_ff;
    reg service_interrupt_flag_ff;
    // direction lives in its own control byte, bit 5
    reg direction_ff;
    reg [2:0] irq_low_wr_ff;
    reg rd_pending_ff;
    reg rd_fifo_ff;
    reg [7:0] rd_sel_ff;
    // reset image of the extended control register
    wire [7:0] ecr_reset_val = `ECR_RESET;

    // fifo pointers (one extra bit for full/empty)
    reg [`FIFO_AW:0] wr_ptr_ff;
    reg [`FIFO_AW:0] rd_ptr_ff;
    wire [`FIFO_AW:0] count = wr_ptr_ff - rd_ptr_ff;
    wire fifo_full = (count == `FIFO_DEPTH);
    wire fifo_empty = (count == 0);
    wire [7:0] mem_rd_data;

    wire in_spp = (mode_ff == `MODE_SPP) || (mode_ff == `MODE_PS2);
    wire in_fifo = (mode_ff == `MODE_FIFO);
    wire in_ecp = (mode_ff == `MODE_ECP);
    wire in_test = (mode_ff == `MODE_TEST);
    wire in_cfg = (mode_ff == `MODE_CFG);
    // fifo mode ignores direction: always forward
    wire fwd_send = in_fifo || (in_ecp && !direction_ff);
    wire rev_recv = in_ecp && direction_ff;

    // bus access decode; waitrequest drops one cycle after a write request, two after a read
    wire req = (avs_read || avs_write) && avs_waitrequest;
    // each request is taken once, at the first edge it meets waitrequest high
    wire rd_take = req && avs_read && !rd_pending_ff;
    wire wr_take = req && avs_write && !rd_pending_ff;
    wire wr_lane0 = wr_take && avs_byteenable[0];
    wire acc_fifo = (avs_address == `OFS_FIFO_PORT);
    // host may push only in modes whose alias is writable
    wire host_push_ok = fwd_send || in_test;
    wire host_pop_ok = rev_recv || in_test;
    wire host_wr_fifo = wr_lane0 && acc_fifo && host_push_ok && !fifo_full;
    wire host_rd_fifo = rd_take && acc_fifo && host_pop_ok && !fifo_empty;

    // dma: request while enabled and fifo has room/data in the direction served
    wire dma_push = dma_ack && dma_transfer_enable_ff && host_push_ok && !rev_recv && !fifo_full;
    wire dma_pop = dma_ack && dma_transfer_enable_ff && host_pop_ok && !fifo_empty
        && !dma_push;

    // link engine
    localparam ST_IDLE = 3'h0;
    localparam ST_LOAD = 3'h1;
    localparam ST_SETUP = 3'h2;
    localparam ST_STROBE = 3'h3;
    localparam ST_WAIT = 3'h4;
    localparam ST_RACK = 3'h5;
    localparam ST_RREL = 3'h6;
    reg [2:0] state_ff;
    reg [7:0] tmr_ff;
    wire link_pop = (state_ff == ST_IDLE) && fwd_send && !fifo_empty;
    wire link_push = (state_ff == ST_RACK) && !fifo_full;

    wire pop = host_rd_fifo || dma_pop || link_pop;
    wire push = host_wr_fifo || dma_push || link_push;
    // dma bytes ride on the write data lanes, there is no separate dma bus
    wire [7:0] push_data = link_push ? pd_sync :
        (host_wr_fifo ? avs_writedata[7:0] : avs_writedata[7:0]);

    // one shared 16-byte store for every alias
    byte_fifo_mem u_mem (
        .core_clk(core_clk),
        .wr_en(push),
        .wr_addr(wr_ptr_ff[`FIFO_AW-1:0]),
        .wr_data(push_data),
        .rd_addr(rd_ptr_ff[`FIFO_AW-1:0]),
        .rd_data_ff(mem_rd_data)
    );

    // pointer next values; standard mode holds both at zero
    reg [`FIFO_AW:0] nxt_wr_ptr;
    reg [`FIFO_AW:0] nxt_rd_ptr;

    always @* begin
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        if (in_spp) begin
            nxt_wr_ptr = {(`FIFO_AW+1){1'b0}};
            nxt_rd_ptr = {(`FIFO_AW+1){1'b0}};
        end else begin
            if (push) begin
                nxt_wr_ptr = wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                nxt_rd_ptr = rd_ptr_ff + 1'b1;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr_ff <= {(`FIFO_AW+1){1'b0}};
            rd_ptr_ff <= {(`FIFO_AW+1){1'b0}};
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    // answer byte: popped head, valid one edge after the pop, or the latched image
    wire [7:0] rd_byte = rd_fifo_ff ? mem_rd_data : rd_sel_ff;

    // bus register behaviour
    wire [7:0] ecr_value = {mode_ff, error_interrupt_disable_ff, dma_transfer_enable_ff,
        service_interrupt_flag_ff, fifo_full, fifo_empty};
    wire [7:0] irq_info_value = {1'b0, irq_sync,
        irq_assign, `IRQ_LOW_BITS};
    reg [7:0] nxt_rd_sel;

    always @* begin
        nxt_rd_sel = 8'h00;
        case (avs_address)
            `OFS_FIFO_PORT: nxt_rd_sel = in_cfg ? `IMPL_INFO_VALUE : 8'h00;
            `OFS_IRQ_INFO: nxt_rd_sel = in_cfg ? irq_info_value : 8'h00;
            `OFS_ECR: nxt_rd_sel = ecr_value;
            // bits 7:6 of the direction byte always read as ones
            `OFS_DCR: nxt_rd_sel = {2'h3, direction_ff, 5'h00};
            `OFS_PORT_STAT: nxt_rd_sel = {4'h0, state_ff, rev_recv};
            default: nxt_rd_sel = 8'h00;
        endcase
    end

    // waitrequest stands low for exactly one cycle per request
    always @(posedge core_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            rd_pending_ff <= 1'b0;
            rd_fifo_ff <= 1'b0;
            rd_sel_ff <= 8'h00;
        end else begin
            avs_waitrequest <= 1'b1;
            rd_pending_ff <= 1'b0;
            if (wr_take) begin
                avs_waitrequest <= 1'b0;
            end
            if (rd_take) begin
                rd_pending_ff <= 1'b1;
                rd_fifo_ff <= host_rd_fifo;
                rd_sel_ff <= nxt_rd_sel;
            end
            if (rd_pending_ff) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= {24'h000000, rd_byte};
            end
        end
    end

    // control register writes land at the take edge
    always @(posedge core_clk) begin
        if (sys_rst) begin
            mode_ff <= ecr_reset_val[`ECR_MODE_HI:`ECR_MODE_LO];
            error_interrupt_disable_ff <= ecr_reset_val[`ECR_ERR_DIS];
            dma_transfer_enable_ff <= ecr_reset_val[`ECR_DMA_EN];
            service_interrupt_flag_ff <= ecr_reset_val[`ECR_SVC];
            direction_ff <= 1'b0;
            irq_low_wr_ff <= `IRQ_LOW_BITS;
        end else if (wr_lane0) begin
            case (avs_address)
                `OFS_ECR: begin
                    mode_ff <= avs_writedata[`ECR_MODE_HI:`ECR_MODE_LO];
                    error_interrupt_disable_ff <= avs_writedata[`ECR_ERR_DIS];
                    dma_transfer_enable_ff <= avs_writedata[`ECR_DMA_EN];
                    service_interrupt_flag_ff <= avs_writedata[`ECR_SVC];
                end
                `OFS_DCR: begin
                    direction_ff <= avs_writedata[5];
                end
                `OFS_IRQ_INFO: begin
                    // stored only, in configuration mode; there these bits always read back as ones
                    if (in_cfg) begin
                        irq_low_wr_ff <= avs_writedata[2:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // dma request level: forward wants room, reverse wants data
    always @(posedge core_clk) begin
        if (sys_rst) begin
            dma_req_ff <= 1'b0;
        end else begin
            dma_req_ff <= dma_transfer_enable_ff &&
                ((host_push_ok && !rev_recv && !fifo_full) || (host_pop_ok && !fifo_empty));
        end
    end

    // handshake engine; test mode starts nothing here
    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            tmr_ff <= 8'h00;
            pd_out_ff <= 8'h00;
            pd_oe_n_ff <= 1'b0;
            strobe_n_ff <= 1'b1;
            host_ack_n_ff <= 1'b1;
        end else begin
            // pins turn around only when the mode or direction changes
            pd_oe_n_ff <= rev_recv;
            case (state_ff)
                ST_IDLE: begin
                    strobe_n_ff <= 1'b1;
                    host_ack_n_ff <= 1'b1;
                    if (link_pop) begin
                        state_ff <= ST_LOAD;
                    end else if (rev_recv && !peri_ack_n_sync && !fifo_full) begin
                        state_ff <= ST_RACK;
                    end else if (in_test && !fifo_empty) begin
                        // test mode only shows the head byte, nothing is strobed
                        pd_out_ff <= mem_rd_data;
                    end
                end
                ST_LOAD: begin
                    // popped byte is valid at mem_rd_data one edge after the pop
                    pd_out_ff <= mem_rd_data;
                    state_ff <= ST_SETUP;
                end
                ST_SETUP: begin
                    tmr_ff <= 8'h00;
                    if (!fwd_send) begin
                        // mode left forward: drop the byte rather than strobe it
                        state_ff <= ST_IDLE;
                    end else if (!busy_sync) begin
                        state_ff <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    // length in clocks, rounded up from the nanosecond figure
                    strobe_n_ff <= 1'b0;
                    tmr_ff <= tmr_ff + 8'h01;
                    if (tmr_ff == `STROBE_CYC) begin
                        strobe_n_ff <= 1'b1;
                        tmr_ff <= 8'h00;
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // a peripheral that never drops busy is left here after ACK_TIMEOUT_CYC cycles; ST_SETUP still waits on busy without limit
                    tmr_ff <= tmr_ff + 8'h01;
                    if (!busy_sync || tmr_ff == `ACK_TIMEOUT_CYC) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_RACK: begin
                    host_ack_n_ff <= 1'b0;
                    state_ff <= ST_RREL;
                end
                ST_RREL: begin
                    // leaving reverse mode releases the ack so it cannot stick low
                    if (peri_ack_n_sync || !rev_recv) begin
                        host_ack_n_ff <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // ecp_port_fifo
`default_nettype wire

// file: bench/ecp_port_fifo_assertions.sv
// Purpose: port-level checks of the printer port fifo block
// Assumes: mode follows completed extended control writes with byte lane 0
// Notes: bound to every ecp_port_fifo instance
`timescale 1ns/1ps
`default_nettype none
`include "ecp_port_defines.vh"
module ecp_port_fifo_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] irq_assign,
    input wire logic pd_oe_n_ff,
    input wire logic strobe_n_ff,
    input wire logic host_ack_n_ff
);
    logic [2:0] mode_ff;
    logic [4:0] low_cnt_ff;
    wire rd_done = avs_read && !avs_waitrequest;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    always @(posedge core_clk) begin
        if (sys_rst)
            mode_ff <= `MODE_SPP;
        else if (avs_write && !avs_waitrequest && avs_address == `OFS_ECR && avs_byteenable[0])
            mode_ff <= avs_writedata[7:5];
        // strobe length counted here, a 13-deep repetition is too costly
        low_cnt_ff <= (sys_rst || strobe_n_ff) ? 5'h00 : low_cnt_ff + 5'h01;
    end
    property p_read_answer;
        $rose(avs_read) |=> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer late or early");
    property p_cfg_a;
        rd_done && avs_address == `OFS_FIFO_PORT && mode_ff == `MODE_CFG
            |-> avs_readdata == {24'h000000, `IMPL_INFO_VALUE};
    endproperty
    a_cfg_a: assert property (p_cfg_a)
        else $error("implementation info wrong");
    property p_cfg_b;
        rd_done && avs_address == `OFS_IRQ_INFO && mode_ff == `MODE_CFG
            |-> avs_readdata[7] == 1'b0 && avs_readdata[5:0] == {irq_assign, `IRQ_LOW_BITS};
    endproperty
    a_cfg_b: assert property (p_cfg_b)
        else $error("irq info wrong");
    property p_ecr_mode;
        rd_done && avs_address == `OFS_ECR |-> avs_readdata[7:5] == mode_ff;
    endproperty
    a_ecr_mode: assert property (p_ecr_mode)
        else $error("mode field readback wrong");
    property p_spp_empty;
        rd_done && avs_address == `OFS_ECR && mode_ff == `MODE_SPP |-> avs_readdata[1:0] == 2'h1;
    endproperty
    a_spp_empty: assert property (p_spp_empty)
        else $error("fifo not empty in standard mode");
    property p_test_quiet;
        mode_ff == `MODE_TEST |-> strobe_n_ff;
    endproperty
    a_test_quiet: assert property (p_test_quiet)
        else $error("strobe in test mode");
    property p_strobe_width;
        $rose(strobe_n_ff) |-> low_cnt_ff >= 5'h0C && low_cnt_ff <= 5'h0E;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe width wrong");
    property p_fwd_drive;
        !strobe_n_ff |-> !pd_oe_n_ff;
    endproperty
    a_fwd_drive: assert property (p_fwd_drive)
        else $error("strobe while pins released");
    property p_rev_release;
        !host_ack_n_ff |-> pd_oe_n_ff;
    endproperty
    a_rev_release: assert property (p_rev_release)
        else $error("reverse ack while driving pins");
endmodule // ecp_port_fifo_checker
bind ecp_port_fifo ecp_port_fifo_checker chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_assign(irq_assign),
    .pd_oe_n_ff(pd_oe_n_ff), .strobe_n_ff(strobe_n_ff), .host_ack_n_ff(host_ack_n_ff));
`default_nettype wire

// file: bench/printer_model.sv
// Purpose: peripheral on the parallel pins
// Assumes: busy held while strobe low and BUSY_CYC cycles after
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module printer_model #(
    parameter BUSY_CYC = 5
) (
    input wire logic core_clk,
    input wire logic [7:0] pd_out_ff,
    input wire logic strobe_n_ff,
    input wire logic host_ack_n_ff,
    output logic busy_in,
    output logic peri_ack_n_in,
    output logic [7:0] pd_in
);
    logic [7:0] got_q[$];
    logic strobe_was = 1'b1;
    int busy_cnt = 0;
    initial begin
        busy_in = 1'b0;
        peri_ack_n_in = 1'b1;
        pd_in = 8'hA5;
    end
    always @(posedge core_clk) begin
        strobe_was <= strobe_n_ff;
        if (strobe_was && !strobe_n_ff)
            got_q.push_back(pd_out_ff);
        busy_cnt <= !strobe_n_ff ? BUSY_CYC : busy_cnt - (busy_cnt != 0);
        busy_in <= !strobe_n_ff || busy_cnt > 1;
    end
    task automatic send(input logic [7:0] b);
        @(posedge core_clk);
        pd_in <= b;
        peri_ack_n_in <= 1'b0;
        do @(posedge core_clk); while (host_ack_n_ff);
        peri_ack_n_in <= 1'b1;
        pd_in <= ~b;
        do @(posedge core_clk); while (!host_ack_n_ff);
    endtask
endmodule // printer_model
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench for the printer port fifo block
// Assumes: one clock, model peripheral on the pins
// Notes: dma acknowledge pulsed once in test mode
`timescale 1ns/1ps
`default_nettype none
`include "ecp_port_defines.vh"
module tb_top;
    logic core_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, irq_line_in = 1'b0;
    logic [7:0] avs_address = 8'h00, pd_in, pd_out_ff;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hF;
    logic [2:0] irq_assign = 3'h0;
    logic avs_waitrequest, dma_req_ff, pd_oe_n_ff, strobe_n_ff, host_ack_n_ff, busy_in;
    logic peri_ack_n_in, err_dis, dma_ack = 1'b0;
    int mismatches = 0, checked = 0;
    always #20 core_clk = ~core_clk;
    ecp_port_fifo dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_line_in(irq_line_in), .irq_assign(irq_assign),
        .dma_ack(dma_ack), .dma_req_ff(dma_req_ff), .pd_in(pd_in), .pd_out_ff(pd_out_ff),
        .pd_oe_n_ff(pd_oe_n_ff), .strobe_n_ff(strobe_n_ff), .host_ack_n_ff(host_ack_n_ff),
        .busy_in(busy_in), .peri_ack_n_in(peri_ack_n_in), .error_interrupt_disable_ff(err_dis));
    printer_model pm (.core_clk(core_clk), .pd_out_ff(pd_out_ff), .strobe_n_ff(strobe_n_ff),
        .host_ack_n_ff(host_ack_n_ff), .busy_in(busy_in), .peri_ack_n_in(peri_ack_n_in),
        .pd_in(pd_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // entered just after an edge; the trailing edge keeps strobes from rising twice in a step
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= !wr;
        // only the watchdog ends a wait that never gets an answer
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    task automatic wait_sent(input int n);
        repeat (3000) if (pm.got_q.size() < n) @(posedge core_clk);
        repeat (60) @(posedge core_clk);
    endtask
    task automatic t_regs;
        chk(err_dis, 32'h1);
        rc(`OFS_ECR, 32'h15);
        avs_byteenable <= 4'h0;
        bus(1'b1, `OFS_ECR, 8'hF4);
        avs_byteenable <= 4'hF;
        rc(`OFS_ECR, 32'h15);
        bus(1'b1, `OFS_ECR, 8'hF4);
        rc(`OFS_FIFO_PORT, 32'h10);
        bus(1'b1, `OFS_IRQ_INFO, 8'h00);
        for (int i = 0; i < 16; i++) begin
            irq_assign <= i[2:0];
            irq_line_in <= i[3];
            repeat (4) @(posedge core_clk);
            rc(`OFS_IRQ_INFO, {24'h000000, 1'b0, i[3], i[2:0], 3'h7});
        end
    endtask
    task automatic t_fwd;
        bus(1'b1, `OFS_ECR, 8'h4C);
        chk(dma_req_ff, 32'h1);
        chk(err_dis, 32'h0);
        bus(1'b1, `OFS_ECR, 8'h54);
        pm.got_q.delete();
        for (int i = 0; i < 3; i++) bus(1'b1, `OFS_FIFO_PORT, 8'hA0 + i[7:0]);
        wait_sent(3);
        for (int i = 0; i < 3; i++) chk(pm.got_q[i], 8'hA0 + i[7:0]);
        rc(`OFS_ECR, 32'h55);
    endtask
    task automatic t_test;
        int n = pm.got_q.size();
        bus(1'b1, `OFS_ECR, 8'hD4);
        for (int i = 0; i < 17; i++) bus(1'b1, `OFS_FIFO_PORT, 8'h30 + i[7:0]);
        chk(pd_out_ff, 32'h30);
        rc(`OFS_ECR, 32'hD6);
        for (int i = 0; i < 16; i++) rc(`OFS_FIFO_PORT, 32'h30 + i);
        rc(`OFS_ECR, 32'hD5);
        chk(pm.got_q.size(), n);
        bus(1'b1, `OFS_FIFO_PORT, 8'h77);
        bus(1'b1, `OFS_ECR, 8'h14);
        rc(`OFS_ECR, 32'h15);
        bus(1'b1, `OFS_ECR, 8'hD4);
        rc(`OFS_ECR, 32'hD5);
        bus(1'b1, `OFS_ECR, 8'hDC);
        avs_writedata <= 32'h0000003C;
        dma_ack <= 1'b1;
        @(posedge core_clk);
        dma_ack <= 1'b0;
        rc(`OFS_FIFO_PORT, 32'h3C);
        rc(`OFS_ECR, 32'hDD);
    endtask
    task automatic t_rev;
        bus(1'b1, `OFS_DCR, 8'h20);
        bus(1'b1, `OFS_ECR, 8'h74);
        for (int i = 0; i < 3; i++) pm.send(8'hC0 + i[7:0]);
        for (int i = 0; i < 3; i++) rc(`OFS_FIFO_PORT, 32'hC0 + i);
        rc(`OFS_FIFO_PORT, 32'h0);
        bus(1'b1, `OFS_DCR, 8'h00);
        pm.got_q.delete();
        bus(1'b1, `OFS_FIFO_PORT, 8'h5A);
        wait_sent(1);
        chk(pm.got_q[0], 32'h5A);
    endtask
    task automatic complete_run;
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_fwd;
        t_test;
        t_rev;
        complete_run;
    end
    initial begin
        #2000000;
        mismatches++;
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
